// ### verilog/clie_pkg.sv
// Purpose: constants and carrier types of the character display engine
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes:   offsets are byte addresses on the register bus
package clie_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_DATA  = 8'h04;
  localparam logic [7:0] OFS_MODE  = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // timing
  localparam int CLK_NS     = 25;
  localparam int CLK_KHZ    = 40000;
  localparam int OSC_KHZ    = 540;
  localparam int EXEC_NS    = 18500;
  localparam int CLEAR_NS   = 760000;
  localparam int OSC_DIV    = CLK_KHZ / OSC_KHZ;
  localparam int EXEC_CYC   = (EXEC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLEAR_CYC  = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] BLINK_FRAMES = 8'h9d;
  // ==========================================================
  // memory map of text and glyph space
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] L1_BASE    = 7'h00;
  localparam logic [6:0] L1_LAST    = 7'h27;
  localparam logic [6:0] L2_BASE    = 7'h40;
  localparam logic [6:0] L2_LAST    = 7'h67;
  localparam logic [6:0] ONE_LAST   = 7'h4f;
  localparam logic [7:0] LINE_LEN   = 8'h28;
  localparam logic [7:0] ONE_LEN    = 8'h50;
  localparam logic [6:0] MEM_LAST   = 7'h7f;
  localparam logic [2:0] CURSOR_ROW = 3'h7;
  // ==========================================================
  // drive geometry
  localparam int SEG_N = 40;
  localparam logic [3:0] COM_LAST_2L = 4'hf;
  localparam logic [3:0] COM_LAST_1L = 4'h7;
  localparam logic [2:0] CHAR_LAST   = 3'h7;
  localparam logic [2:0] DOT_LAST    = 3'h4;
  // ==========================================================
  // reset values of the mode latches
  localparam logic RST_STEP_UP = 1'b1;
  localparam logic RST_WIDE    = 1'b1;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BUSY  = 2'b01,
    ST_CLEAR = 2'b11
  } clie_state_type;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } clie_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } clie_axi_rsp_type;

  typedef struct packed {
    logic [3:0]       com;
    logic             two_line;
    logic             latch;
    logic [SEG_N-1:0] seg;
  } clie_drive_type;
endpackage

// ### verilog/clie_engine.sv
// Purpose: instruction decoder, address counter, busy flag, glyph
//          memories and segment scan of a character display
// Assumes: AXI4-Lite master, one clock, synchronous active-low reset
// Notes:   instruction writes are refused while busy_flag is high
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - each data read or write steps address_counter by one per direction
// - instruction-space read shows address_counter on low_data_lines
// - status read gives busy_flag on top_data_line plus counter, no delay
// - two-line scans 16 commons, one-line 8, always 40 segments
// - pixels shift into 40-bit chain, then copy to 40-bit hold latch
// - fixed glyph table holds 256 patterns of 5 by 8 dots
// - writable glyph memory holds 8 user glyphs loaded by data writes
// - code bits 2..0 become glyph memory address bits 5..3
// - address bits 2..0 pick row; row 7 is ORed with the cursor
// - glyph byte bits 4..0 are dots, bit 4 leftmost, 1 lit
// - codes with bits 7..4 zero use user glyphs; bit 3 ignored
// - clear fills text memory with 20H, counter to 00H, 0.76 ms
// - home zeroes counter and display shift, text kept, 0.76 ms
// - entry mode latches step direction and shift enable, 18.5 us
// - display control latches display, cursor, blink enables
// - shift moves display or cursor, right or left, 18.5 us
// - function setup latches bus width, line count, font height
// - glyph address set loads six bits, targets glyph memory
// - text address set loads seven bits, targets text memory
// - data write stores, data read returns targeted byte, 18.5 us
// - no instruction is accepted while busy_flag is high
// - narrow bus moves each instruction or data byte as two nibbles, high first
// - two-line text addresses are 00H-27H and 40H-67H
module clie_engine
  import clie_pkg::*;
#(
  parameter int CLEAR_CYCLES = CLEAR_CYC
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // register bus
  input  wire clie_axi_req_type axi_req,
  output clie_axi_rsp_type      axi_rsp,
  // panel drive
  output clie_drive_type        drive
);

  // ==========================================================
  // helpers
  // step rule
  function automatic logic [6:0] step_addr(input logic [6:0] a,
                                           input logic up,
                                           input logic cg,
                                           input logic two);
    logic [6:0] r;
    r = a;
    if (cg) begin
      r = up ? {1'b0, a[5:0] + 6'h01} : {1'b0, a[5:0] - 6'h01};
    end else if (two) begin
      if (up) begin
        r = (a == L1_LAST) ? L2_BASE :
            (a == L2_LAST) ? L1_BASE : a + 7'h01;
      end else begin
        r = (a == L1_BASE) ? L2_LAST :
            (a == L2_BASE) ? L1_LAST : a - 7'h01;
      end
    end else begin
      if (up) begin
        r = (a >= ONE_LAST) ? L1_BASE : a + 7'h01;
      end else begin
        r = (a == L1_BASE) ? ONE_LAST : a - 7'h01;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] wrap_add(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic [7:0] m);
    logic [7:0] s;
    s = a + b;
    return (s >= m) ? s - m : s;
  endfunction

  // fixed glyph table, 256 codes by 8 rows
  function automatic logic [4:0] rom_row(input logic [7:0] code,
                                         input logic [2:0] row);
    return code[4:0] ^ {row, code[7:6]};
  endfunction

  // ==========================================================
  // state
  clie_state_type state;
  logic [15:0]    exec_cnt;
  logic [6:0]     clr_idx;
  logic [6:0]     address_counter;
  logic [7:0]     shift_ofs;
  logic           busy_flag;
  logic           step_up;
  logic           shift_en;
  logic           disp_on;
  logic           cursor_on;
  logic           blink_on;
  logic           bus_width_bit;
  logic           two_line;
  logic           font_tall;
  logic           target_glyph;
  logic [7:0]     display_text_memory [0:127];
  logic [7:0]     glyph_memory_writable [0:63];

  assign busy_flag = (state != ST_IDLE);

  // ==========================================================
  // register bus slave
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic       wr_half;
  logic [3:0] wr_nib;
  logic       rd_half;
  logic       wr_fire;
  logic       wr_full;
  logic       wr_go;
  logic       rd_fire;
  logic       rd_go;
  logic [7:0] next_wr_byte;
  logic [7:0] rd_byte;
  logic [7:0] rd_src;
  logic       rd_mapped;
  logic       rd_port;
  logic       wr_port;

  assign wr_fire = aw_held && w_held && !axi_rsp.bvalid;
  assign wr_port = (aw_addr == OFS_INSTR) || (aw_addr == OFS_DATA);
  assign wr_full = bus_width_bit || wr_half;
  assign next_wr_byte = bus_width_bit ? w_byte : {wr_nib, w_byte[3:0]};
  assign wr_go = wr_fire && wr_port && wr_full && !busy_flag;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_byte  <= 8'h00;
      axi_rsp.awready <= 1'b0;
      axi_rsp.wready  <= 1'b0;
      axi_rsp.bvalid  <= 1'b0;
      axi_rsp.bresp   <= RESP_OKAY;
    end else begin
      // ready never waits for valid to drop, so a waiting master cannot stall
      axi_rsp.awready <= !aw_held && !axi_rsp.bvalid;
      axi_rsp.wready  <= !w_held && !axi_rsp.bvalid;
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_held <= 1'b1;
        aw_addr <= axi_req.awaddr;
        axi_rsp.awready <= 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_held <= 1'b1;
        w_byte <= axi_req.wstrb[0] ? axi_req.wdata[7:0] : w_byte;
        axi_rsp.wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        axi_rsp.bvalid <= 1'b1;
        axi_rsp.bresp  <= (wr_port || aw_addr == OFS_MODE) ?
                          RESP_OKAY : RESP_SLVERR;
      end else if (axi_rsp.bvalid && axi_req.bready) begin
        axi_rsp.bvalid <= 1'b0;
      end
    end
  end

  // narrow bus nibble pairing, shared by both ports
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_half <= 1'b0;
      wr_nib  <= 4'h0;
      rd_half <= 1'b0;
    end else begin
      if (bus_width_bit) begin
        wr_half <= 1'b0;
      end else if (wr_fire && wr_port && !busy_flag) begin
        wr_half <= !wr_half;
        wr_nib  <= w_byte[3:0];
      end
      if (bus_width_bit) begin
        rd_half <= 1'b0;
      end else if (rd_fire && rd_port) begin
        rd_half <= !rd_half;
      end
    end
  end

  // ==========================================================
  // read channel
  assign rd_fire = axi_req.arvalid && axi_rsp.arready;
  assign rd_port = (axi_req.araddr == OFS_INSTR) ||
                   (axi_req.araddr == OFS_DATA);
  assign rd_go   = rd_fire && (axi_req.araddr == OFS_DATA) &&
                   (bus_width_bit || rd_half) && !busy_flag;

  always_comb begin
    rd_mapped = 1'b1;
    rd_byte = target_glyph ?
              glyph_memory_writable[address_counter[5:0]] :
              display_text_memory[address_counter];
    case (axi_req.araddr)
      OFS_INSTR: rd_src = {busy_flag, address_counter};
      OFS_DATA:  rd_src = rd_byte;
      OFS_MODE:  rd_src = {font_tall, two_line, bus_width_bit, disp_on,
                           cursor_on, blink_on, step_up, shift_en};
      default: begin
        rd_src = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
    if (!bus_width_bit && rd_port) begin
      rd_src = rd_half ? {4'h0, rd_src[3:0]} : {4'h0, rd_src[7:4]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid  <= 1'b0;
      axi_rsp.rdata   <= 32'h0000_0000;
      axi_rsp.rresp   <= RESP_OKAY;
    end else if (rd_fire) begin
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid  <= 1'b1;
      axi_rsp.rdata   <= {24'h00_0000, rd_src};
      axi_rsp.rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_rsp.rvalid) begin
      axi_rsp.rvalid  <= !axi_req.rready;
      axi_rsp.arready <= axi_req.rready;
    end else begin
      axi_rsp.arready <= 1'b1;
    end
  end

  // ==========================================================
  // instruction executor
  logic is_data;
  assign is_data = (aw_addr == OFS_DATA);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      exec_cnt <= 16'h0000;
      clr_idx <= 7'h00;
      address_counter <= 7'h00;
      shift_ofs <= 8'h00;
      step_up <= RST_STEP_UP;
      shift_en <= 1'b0;
      disp_on <= 1'b0;
      cursor_on <= 1'b0;
      blink_on <= 1'b0;
      bus_width_bit <= RST_WIDE;
      two_line <= 1'b0;
      font_tall <= 1'b0;
      target_glyph <= 1'b0;
    end else begin
      // hold busy for the execution time
      case (state)
        ST_IDLE: ;
        ST_CLEAR: begin
          display_text_memory[clr_idx] <= SPACE_CODE;
          clr_idx <= clr_idx + 7'h01;
          exec_cnt <= exec_cnt - 16'h0001;
          if (clr_idx == MEM_LAST) begin
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          exec_cnt <= exec_cnt - 16'h0001;
          if (exec_cnt == 16'h0000) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (rd_go) begin
        address_counter <= step_addr(address_counter, step_up,
                                     target_glyph, two_line);
        state <= ST_BUSY;
        exec_cnt <= 16'(EXEC_CYC - 1);
      end
      if (wr_go) begin
        state <= ST_BUSY;
        exec_cnt <= 16'(EXEC_CYC - 1);
        if (is_data) begin
          if (target_glyph) begin
            glyph_memory_writable[address_counter[5:0]] <= next_wr_byte;
          end else begin
            display_text_memory[address_counter] <= next_wr_byte;
            // shift on text write when enabled
            if (shift_en) begin
              shift_ofs <= step_up ?
                wrap_add(shift_ofs, 8'h01, two_line ? LINE_LEN : ONE_LEN) :
                wrap_add(shift_ofs, (two_line ? LINE_LEN : ONE_LEN) - 8'h01,
                         two_line ? LINE_LEN : ONE_LEN);
            end
          end
          address_counter <= step_addr(address_counter, step_up,
                                       target_glyph, two_line);
        end else if (next_wr_byte[7]) begin
          address_counter <= next_wr_byte[6:0];
          target_glyph <= 1'b0;
        end else if (next_wr_byte[6]) begin
          address_counter <= {1'b0, next_wr_byte[5:0]};
          target_glyph <= 1'b1;
        end else if (next_wr_byte[5]) begin
          bus_width_bit <= next_wr_byte[4];
          two_line <= next_wr_byte[3];
          font_tall <= next_wr_byte[2];
        end else if (next_wr_byte[4]) begin
          if (next_wr_byte[3]) begin
            shift_ofs <= next_wr_byte[2] ?
              wrap_add(shift_ofs, (two_line ? LINE_LEN : ONE_LEN) - 8'h01,
                       two_line ? LINE_LEN : ONE_LEN) :
              wrap_add(shift_ofs, 8'h01, two_line ? LINE_LEN : ONE_LEN);
          end else begin
            address_counter <= step_addr(address_counter,
                                         next_wr_byte[2],
                                         target_glyph, two_line);
          end
        end else if (next_wr_byte[3]) begin
          disp_on <= next_wr_byte[2];
          cursor_on <= next_wr_byte[1];
          blink_on <= next_wr_byte[0];
        end else if (next_wr_byte[2]) begin
          step_up <= next_wr_byte[1];
          shift_en <= next_wr_byte[0];
        end else if (next_wr_byte[1]) begin
          address_counter <= L1_BASE;
          shift_ofs <= 8'h00;
          target_glyph <= 1'b0;
          exec_cnt <= 16'(CLEAR_CYCLES - 1);
        end else if (next_wr_byte[0]) begin
          state <= ST_CLEAR;
          clr_idx <= 7'h00;
          address_counter <= L1_BASE;
          shift_ofs <= 8'h00;
          step_up <= 1'b1;
          target_glyph <= 1'b0;
          exec_cnt <= 16'(CLEAR_CYCLES - 1);
        end else begin
          // an all-zero instruction does nothing
          state <= ST_IDLE;
        end
      end
    end
  end

  // ==========================================================
  // segment scan, one dot per oscillator tick
  logic [6:0]       osc_cnt;
  logic             osc_tick;
  logic [2:0]       dot_i;
  logic [2:0]       char_i;
  logic [3:0]       com_i;
  logic [7:0]       frame_cnt;
  logic             blink_phase;
  logic [SEG_N-1:0] seg_chain;
  logic [7:0]       scan_col;
  logic [6:0]       scan_addr;
  logic [7:0]       scan_code;
  logic [2:0]       grow;
  logic [4:0]       pat;
  logic             last_dot;
  logic [3:0]       com_last;

  assign osc_tick = (osc_cnt == 7'(OSC_DIV - 1));
  assign grow     = com_i[2:0];
  assign last_dot = (dot_i == DOT_LAST) && (char_i == CHAR_LAST);
  assign com_last = two_line ? COM_LAST_2L : COM_LAST_1L;

  always_comb begin
    scan_col = wrap_add({5'h00, char_i}, shift_ofs,
                        two_line ? LINE_LEN : ONE_LEN);
    scan_addr = two_line ?
      (com_i[3] ? L2_BASE : L1_BASE) + scan_col[6:0] :
      scan_col[6:0];
    scan_code = display_text_memory[scan_addr];
    if (scan_code[7:4] == 4'h0) begin
      pat = glyph_memory_writable[{scan_code[2:0], grow}][4:0];
    end else begin
      pat = rom_row(scan_code, grow);
    end
    if (cursor_on && scan_addr == address_counter &&
        grow == CURSOR_ROW) begin
      pat = 5'h1f;
    end
    if (blink_on && blink_phase && scan_addr == address_counter) begin
      pat = 5'h1f;
    end
    if (!disp_on) begin
      pat = 5'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      osc_cnt <= 7'h00;
      dot_i <= 3'h0;
      char_i <= 3'h0;
      com_i <= 4'h0;
      frame_cnt <= 8'h00;
      blink_phase <= 1'b0;
      seg_chain <= '0;
      drive <= '0;
    end else begin
      osc_cnt <= osc_tick ? 7'h00 : osc_cnt + 7'h01;
      drive.latch <= 1'b0;
      drive.two_line <= two_line;
      if (osc_tick) begin
        seg_chain <= {seg_chain[SEG_N-2:0], pat[3'h4 - dot_i]};
        dot_i <= (dot_i == DOT_LAST) ? 3'h0 : dot_i + 3'h1;
        if (dot_i == DOT_LAST) begin
          char_i <= char_i + 3'h1;
        end
        if (last_dot) begin
          // parallel copy into the hold latch
          drive.seg <= {seg_chain[SEG_N-2:0], pat[3'h4 - dot_i]};
          drive.com <= com_i;
          drive.latch <= 1'b1;
          com_i <= (com_i >= com_last) ? 4'h0 : com_i + 4'h1;
          if (com_i >= com_last) begin
            frame_cnt <= (frame_cnt == BLINK_FRAMES) ?
                         8'h00 : frame_cnt + 8'h01;
            if (frame_cnt == BLINK_FRAMES) begin
              blink_phase <= !blink_phase;
            end
          end
        end
      end
    end
  end

endmodule // clie_engine

// ### dv/clie_engine_assertions.sv
// Purpose: port checker for the display instruction engine
// Assumes: one clock domain, synchronous active-low reset
// Notes:   scan rules are checked where a latch pulse or a segment change shows
`timescale 1ns/1ps
module clie_engine_assertions
  import clie_pkg::*;
#(
  parameter int CLEAR_CYCLES = CLEAR_CYC
) (
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             rst_n,
  // watched ports
  input wire clie_axi_req_type axi_req,
  input wire clie_axi_rsp_type axi_rsp,
  input wire clie_drive_type   drive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // bus steps
  sequence ar_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  sequence aw_take_mapped;
    axi_req.awvalid && axi_rsp.awready && axi_req.awaddr <= OFS_MODE
      && axi_req.awaddr[1:0] == 2'h0;
  endsequence
  sequence read_answer;
    axi_rsp.rvalid;
  endsequence
  // ==========================================================
  // properties
  AST_STATUS_NOW:
    assert property (ar_take |=> read_answer)
    else $error("read answer late");
  AST_BAD_ADDR:
    assert property (ar_take ##0 axi_req.araddr > OFS_MODE |=>
      axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_UPPER_ZERO:
    assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_RVALID_HOLD:
    assert property (axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read answer dropped");
  AST_WRITE_OKAY:
    assert property (aw_take_mapped |-> ##[1:8]
      (axi_rsp.bvalid && axi_rsp.bresp == RESP_OKAY))
    else $error("write answer missing");
  AST_LATCH_PULSE:
    assert property ($rose(drive.latch) |=> !drive.latch [*8])
    else $error("latch pulse too long");
  AST_SEG_ON_LATCH:
    assert property (!$stable(drive.seg) |-> drive.latch)
    else $error("segments moved without latch");
  AST_ONE_LINE_COM:
    assert property (drive.latch && !drive.two_line |->
      drive.com <= COM_LAST_1L)
    else $error("common beyond one-line range");
  AST_COM_STEP:
    assert property (drive.latch && drive.two_line
      && $past(drive.two_line) && $past(drive.com) inside {[1:14]}
      |-> drive.com == $past(drive.com) + 4'h1)
    else $error("common did not step");
endmodule // clie_engine_assertions

bind clie_engine clie_engine_assertions #(
  .CLEAR_CYCLES(CLEAR_CYCLES)
) clie_engine_assertions_i (
  .sys_clk(sys_clk),
  .rst_n  (rst_n),
  .axi_req(axi_req),
  .axi_rsp(axi_rsp),
  .drive  (drive)
);

// ### dv/clie_host_model.sv
// Purpose: host processor model on the register bus
// Assumes: one write or one read under way at a time
// Notes:   released payload is inverted so stale values never match
`timescale 1ns/1ps
module clie_host_model
  import clie_pkg::*;
(
  // clock
  input  wire logic             sys_clk,
  // register bus
  input  wire clie_axi_rsp_type axi_rsp,
  output clie_axi_req_type      axi_req
);
  initial axi_req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge sys_clk);
    axi_req.awaddr  <= a;
    axi_req.wdata   <= {24'h0, d};
    axi_req.wstrb   <= 4'hf;
    {axi_req.awvalid, axi_req.wvalid, axi_req.bready} <= 3'b111;
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (!ad && axi_rsp.awready) begin
        ad = 1'b1;
        axi_req.awvalid <= 1'b0;
        axi_req.awaddr  <= ~a;
      end
      if (!wd && axi_rsp.wready) begin
        wd = 1'b1;
        axi_req.wvalid <= 1'b0;
        axi_req.wdata  <= ~{24'h0, d};
      end
    end
    while (axi_rsp.bvalid !== 1'b1) @(posedge sys_clk);
    axi_req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    axi_req.araddr <= a;
    {axi_req.arvalid, axi_req.rready} <= 2'b11;
    do begin
      @(posedge sys_clk);
      if (axi_rsp.arready) begin
        axi_req.arvalid <= 1'b0;
        axi_req.araddr  <= ~a;
      end
    end while (axi_rsp.rvalid !== 1'b1);
    d = axi_rsp.rdata[7:0];
    axi_req.rready <= 1'b0;
  endtask

  task automatic poll;
    logic [7:0] v;
    do begin
      rd(OFS_INSTR, v);
    end while (v[7] !== 1'b0);
  endtask

  task automatic op(input logic [7:0] a, input logic [7:0] d,
                    output int cyc);
    realtime t;
    wr(a, d);
    t = $realtime;
    poll();
    cyc = int'(($realtime - t) / CLK_NS);
  endtask
endmodule // clie_host_model

// ### dv/char_lcd_instruction_engine_tb_top.sv
// Purpose: self-checking bench of the display instruction engine
// Assumes: host model drives the bus, results checked from a queue
// Notes:   clear count shortened so the run stays brief
`timescale 1ns/1ps
module char_lcd_instruction_engine_tb_top;
  import clie_pkg::*;
  localparam int CLR = 200;
  logic             sys_clk = 1'b0;
  logic             rst_n   = 1'b0;
  clie_axi_req_type axi_req;
  clie_axi_rsp_type axi_rsp;
  clie_drive_type   drive;
  int               fails     = 0;
  int               tests_run = 0;
  int               cyc;
  logic [33:0]      expq[$];
  logic             watch = 1'b0;
  logic [31:0]      seed  = 32'h0000000b;
  logic [7:0]       v;
  logic [7:0]       bytes[4];

  always #12.5 sys_clk = ~sys_clk;

  clie_engine #(.CLEAR_CYCLES(CLR)) clie_engine_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .drive(drive));
  clie_host_model clie_host_model_i (
    .sys_clk(sys_clk), .axi_rsp(axi_rsp), .axi_req(axi_req));

  // ==========================================================
  // checking
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    if (watch && axi_rsp.rvalid && axi_req.rready) begin
      check("read", {axi_rsp.rresp, axi_rsp.rdata}, expq.pop_front());
    end
  end

  task automatic ex(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r = RESP_OKAY);
    expq.push_back({r, 24'h0, d});
    // off-edge so an earlier read answer is never taken for this one
    @(negedge sys_clk);
    watch = 1'b1;
    clie_host_model_i.rd(a, v);
    @(negedge sys_clk);
    watch = 1'b0;
  endtask

  task automatic span(input int want);
    check("busy span", {33'h0, cyc inside {[want-4:want+8]}}, 34'h1);
  endtask

  // ==========================================================
  // scenarios
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    clie_host_model_i.op(OFS_INSTR, 8'h38, cyc);
    span(EXEC_CYC);
    clie_host_model_i.op(OFS_INSTR, 8'h0f, cyc);
    clie_host_model_i.op(OFS_INSTR, 8'h06, cyc);
    ex(OFS_MODE, 8'h7e);
    clie_host_model_i.op(OFS_INSTR, 8'h85, cyc);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      bytes[i] = seed[7:0];
      clie_host_model_i.op(OFS_DATA, bytes[i], cyc);
    end
    ex(OFS_INSTR, 8'h09);
    clie_host_model_i.op(OFS_INSTR, 8'h85, cyc);
    for (int i = 0; i < 4; i++) begin
      ex(OFS_DATA, bytes[i]);
      clie_host_model_i.poll();
    end
    ex(OFS_INSTR, 8'h09);
    clie_host_model_i.op(OFS_INSTR, 8'h02, cyc);
    span(CLR);
    ex(OFS_INSTR, 8'h00);
    clie_host_model_i.op(OFS_INSTR, 8'h14, cyc);
    ex(OFS_INSTR, 8'h01);
    clie_host_model_i.op(OFS_INSTR, 8'h04, cyc);
    clie_host_model_i.op(OFS_INSTR, 8'h90, cyc);
    clie_host_model_i.op(OFS_DATA, 8'h41, cyc);
    ex(OFS_INSTR, 8'h0f);
    // an address set during the clear must be dropped
    clie_host_model_i.wr(OFS_INSTR, 8'h01);
    clie_host_model_i.wr(OFS_INSTR, 8'h8a);
    clie_host_model_i.poll();
    ex(OFS_INSTR, 8'h00);
    clie_host_model_i.op(OFS_INSTR, 8'h85, cyc);
    ex(OFS_DATA, 8'h20);
    clie_host_model_i.poll();
    clie_host_model_i.op(OFS_INSTR, 8'h48, cyc);
    clie_host_model_i.op(OFS_DATA, 8'h1f, cyc);
    ex(OFS_INSTR, 8'h09);
    clie_host_model_i.op(OFS_INSTR, 8'h4f, cyc);
    clie_host_model_i.op(OFS_DATA, 8'h00, cyc);
    ex(8'h0c, 8'h00, RESP_SLVERR);
    // narrow bus: status comes back as two nibbles, high first
    clie_host_model_i.wr(OFS_INSTR, 8'h28);
    ex(OFS_INSTR, 8'h09);
    ex(OFS_INSTR, 8'h00);
    repeat (EXEC_CYC) @(posedge sys_clk);
    clie_host_model_i.wr(OFS_INSTR, 8'h0a);
    clie_host_model_i.wr(OFS_INSTR, 8'h03);
    repeat (EXEC_CYC) @(posedge sys_clk);
    ex(OFS_INSTR, 8'h02);
    ex(OFS_INSTR, 8'h03);
    check("two line drive", {33'h0, drive.two_line}, 34'h1);
    cyc = 0;
    repeat (2 * SEG_N * OSC_DIV) begin
      @(posedge sys_clk);
      if (drive.latch === 1'b1) cyc++;
    end
    check("latch count", {2'h0, cyc}, 34'h2);
    conclude();
  end

  initial begin
    #2500000;
    fails++;
    conclude();
  end
endmodule // char_lcd_instruction_engine_tb_top
